// *** common/scs_if.sv ***
// four-wire serial link between the controller and the sensor port
`timescale 1ns/1ns
interface scs_if;
    logic sck;
    logic ss_n;
    logic mosi;
    logic miso;
    logic miso_oe;

    modport dev (
        input  sck,
        input  ss_n,
        input  mosi,
        output miso,
        output miso_oe
    );

    modport host (
        output sck,
        output ss_n,
        output mosi,
        input  miso
    );
endinterface

// *** common/scs_pkg.sv ***
// shared constants for the sensor configuration serial port, both ends
package scs_pkg;
    // frame layout: address, direction bit, data word
    localparam int ADDR_W      = 9;
    localparam int DATA_W      = 16;
    localparam int FRAME_BITS  = ADDR_W + 1 + DATA_W;
    localparam int CNT_W       = 5;
    localparam int IDX_W       = 4;
    localparam logic DIR_WRITE = 1'b1;
    localparam logic DIR_READ  = 1'b0;

    // positions inside the device shift register after 25 bits
    localparam int SH_W        = FRAME_BITS - 1;
    localparam int SH_ADDR_LSB = SH_W - ADDR_W;
    localparam int SH_DATA_TOP = DATA_W - 2;

    // timing: periods in ns, lead/trail/gap in sck periods, SCK_HALF in system cycles
    localparam int SYS_PERIOD_NS = 50;
    localparam int TSCK_NS       = 100;
    localparam int LEAD_TSCK     = 1;
    localparam int TRAIL_TSCK    = 1;
    localparam int GAP_TSCK      = 2;
    localparam int SCK_HALF      = (TSCK_NS + 2 * SYS_PERIOD_NS - 1) / (2 * SYS_PERIOD_NS);

    // serial clock ceiling against the lvds input clock
    localparam int LVDS_MHZ_10BIT = 340;
    localparam int LVDS_MHZ_8BIT  = 272;
    localparam int LVDS_DIV_10BIT = 30;
    localparam int LVDS_DIV_8BIT  = 24;

    localparam int PH_W = 8;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_LEAD  = 3'b001,
        ST_SHIFT = 3'b010,
        ST_TRAIL = 3'b011,
        ST_GAP   = 3'b100
    } scs_host_state_t;
endpackage

// *** core/scs_dev.sv ***
// sensor end: serial slave with its configuration register array
`timescale 1ns/1ns
module scs_dev (
    input  wire logic                       clk_sys,
    input  wire logic                       sys_rst,
    scs_if.dev                              link,
    output logic                            cfg_wr_valid,
    output logic [scs_pkg::ADDR_W-1:0]      cfg_wr_addr,
    output logic [scs_pkg::DATA_W-1:0]      cfg_wr_data
);
    import scs_pkg::*;

    logic [DATA_W-1:0] regs [0:(1<<ADDR_W)-1];
    logic [CNT_W-1:0]  cnt;
    logic [SH_W-1:0]   sh;
    logic              is_read;
    logic [DATA_W-1:0] rd_word;
    logic [ADDR_W-1:0] wr_addr_l;
    logic [DATA_W-1:0] wr_data_l;
    logic              wr_tog;
    logic              tog_s1;
    logic              tog_s2;
    logic              tog_seen;

    localparam logic [CNT_W-1:0] CNT_DIR  = CNT_W'(ADDR_W);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(FRAME_BITS - 1);
    localparam logic [CNT_W-1:0] CNT_END  = CNT_W'(FRAME_BITS);

    wire               at_dir    = (cnt == CNT_DIR);
    wire               wr_done   = !link.ss_n && (cnt == CNT_LAST) && !is_read;
    wire [ADDR_W-1:0]  rd_addr   = sh[ADDR_W-1:0];
    wire [ADDR_W-1:0]  fr_addr   = sh[SH_W-1:SH_ADDR_LSB];
    wire [DATA_W-1:0]  fr_data   = {sh[SH_DATA_TOP:0], link.mosi};
    wire [CNT_W-1:0]   rd_pos    = CNT_LAST - cnt;
    wire               in_rd_win = is_read && (cnt > CNT_DIR) && (cnt <= CNT_LAST);
    wire               tog_new   = tog_s2 != tog_seen;

    // frame state lives on sck; select high clears it, since sck may stop
    always_ff @(posedge link.sck or posedge link.ss_n) begin
        if (link.ss_n) begin
            cnt     <= '0;
            is_read <= 1'b0;
        end else begin
            if (cnt != CNT_END)
                cnt <= cnt + 1'b1;
            if (at_dir)
                is_read <= (link.mosi == DIR_READ);
        end
    end

    always_ff @(posedge link.sck) begin
        sh <= {sh[SH_W-2:0], link.mosi};
        if (at_dir)
            rd_word <= regs[rd_addr];
    end

    // only the 26th bit commits; an early deselect never gets here
    always_ff @(posedge link.sck) begin
        if (wr_done) begin
            regs[fr_addr] <= fr_data;
            wr_addr_l     <= fr_addr;
            wr_data_l     <= fr_data;
        end
    end

    always_ff @(posedge link.sck or posedge sys_rst) begin
        if (sys_rst)
            wr_tog <= 1'b0;
        else if (wr_done)
            wr_tog <= ~wr_tog;
    end

    // read data leaves on falling edges, master takes it on the next fall
    always_ff @(negedge link.sck or posedge link.ss_n) begin
        if (link.ss_n) begin
            link.miso_oe <= 1'b0;
            link.miso    <= 1'b0;
        end else begin
            link.miso_oe <= in_rd_win;
            link.miso    <= rd_word[rd_pos[IDX_W-1:0]];
        end
    end

    // write events reach the system clock as a toggle; data held until next write
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            tog_s1       <= 1'b0;
            tog_s2       <= 1'b0;
            tog_seen     <= 1'b0;
            cfg_wr_valid <= 1'b0;
            cfg_wr_addr  <= '0;
            cfg_wr_data  <= '0;
        end else begin
            tog_s1       <= wr_tog;
            tog_s2       <= tog_s1;
            tog_seen     <= tog_s2;
            cfg_wr_valid <= tog_new;
            if (tog_new) begin
                cfg_wr_addr <= wr_addr_l;
                cfg_wr_data <= wr_data_l;
            end
        end
    end
endmodule

// *** core/scs_host.sv ***
// controller end: serial master that makes sck and runs one access per request
// What this block does
// - four wires: clock, select, data in, out
// - sensor port runs on sck, crosses domains
// - master starts each access by select low
// - nine address bits, sixteen data bits
// - wait one sck period, then address msb
// - slave samples rising, master changes falling
// - tenth bit: one writes, zero reads
// - write sends sixteen data bits, msb first
// - read returns sixteen bits on miso
// - master samples miso on falling edges
// - miso high impedance unless returning data
// - one sck period after last bit, deselect
// - sck at most lvds clock/30 or /24
// - two sck periods deselected between accesses
`timescale 1ns/1ns
module scs_host #(
    parameter int HALF      = scs_pkg::SCK_HALF,
    parameter int LVDS_MHZ  = scs_pkg::LVDS_MHZ_10BIT,
    parameter bit EIGHT_BIT = 1'b0
) (
    input  wire logic                       clk_sys,
    input  wire logic                       sys_rst,
    input  wire logic                       req_valid,
    output logic                            req_ready,
    input  wire logic                       req_write,
    input  wire logic [scs_pkg::ADDR_W-1:0] req_addr,
    input  wire logic [scs_pkg::DATA_W-1:0] req_wdata,
    output logic                            rsp_valid,
    output logic [scs_pkg::DATA_W-1:0]      rsp_rdata,
    scs_if.host                             link
);
    import scs_pkg::*;

    localparam int DIV = EIGHT_BIT ? LVDS_DIV_8BIT : LVDS_DIV_10BIT;

    // sck period is 2*HALF system cycles; it must respect the lvds ceiling
    if (HALF < 1 || 2 * GAP_TSCK * HALF > (1 << PH_W)) begin : g_bad_half
        $error("scs_host: HALF out of range");
    end
    if (2 * HALF * SYS_PERIOD_NS * LVDS_MHZ < DIV * 1000) begin : g_too_fast
        $error("scs_host: sck faster than lvds clock allows");
    end
    if (2 * HALF * SYS_PERIOD_NS < TSCK_NS) begin : g_below_tsck
        $error("scs_host: sck period below nominal");
    end

    localparam logic [PH_W-1:0]  HALF_M1  = PH_W'(HALF - 1);
    localparam logic [PH_W-1:0]  LEAD_M1  = PH_W'(2 * LEAD_TSCK * HALF - 1);
    localparam logic [PH_W-1:0]  FULL_M1  = PH_W'(2 * HALF - 1);
    localparam logic [PH_W-1:0]  TRAIL_M1 = PH_W'(2 * TRAIL_TSCK * HALF - 1);
    localparam logic [PH_W-1:0]  GAP_M1   = PH_W'(2 * GAP_TSCK * HALF - 1);
    localparam logic [CNT_W-1:0] LAST_BIT = CNT_W'(FRAME_BITS - 1);

    scs_host_state_t         state;
    scs_host_state_t         next_state;
    logic [PH_W-1:0]         ph;
    logic [PH_W-1:0]         next_ph;
    logic [CNT_W-1:0]        bitn;
    logic [CNT_W-1:0]        next_bitn;
    logic [FRAME_BITS-1:0]   frame;
    logic [FRAME_BITS-1:0]   next_frame;
    logic                    is_write;
    logic                    next_is_write;
    logic                    sck_q;
    logic                    next_sck;
    logic                    ss_n_q;
    logic                    next_ss_n;
    logic                    mosi_q;
    logic                    next_mosi;
    logic                    next_fall;
    logic                    next_rsp;
    logic                    samp_pend;
    logic                    miso_s1;
    logic                    miso_s2;
    logic [DATA_W-1:0]       rx;

    wire                     ph_half = (ph == HALF_M1);
    wire                     ph_full = (ph == FULL_M1);
    wire                     bit_last = (bitn == LAST_BIT);
    wire [DATA_W-1:0]        tx_data = req_write ? req_wdata : '0;
    wire [FRAME_BITS-1:0]    tx_frame = {req_addr, req_write, tx_data};
    wire [FRAME_BITS-1:0]    frame_shl = {frame[FRAME_BITS-2:0], 1'b0};

    assign req_ready = (state == ST_IDLE);
    assign link.sck  = sck_q;
    assign link.ss_n = ss_n_q;
    assign link.mosi = mosi_q;

    always_comb begin
        next_state    = state;
        next_ph       = ph + 1'b1;
        next_bitn     = bitn;
        next_frame    = frame;
        next_is_write = is_write;
        next_sck      = sck_q;
        next_ss_n     = ss_n_q;
        next_mosi     = mosi_q;
        next_fall     = 1'b0;
        next_rsp      = 1'b0;
        case (state)
            ST_IDLE: begin
                next_ph = '0;
                if (req_valid) begin
                    next_state    = ST_LEAD;
                    next_ss_n     = 1'b0;
                    next_frame    = tx_frame;
                    next_is_write = req_write;
                    next_mosi     = req_addr[ADDR_W-1];
                    next_bitn     = '0;
                end
            end
            ST_LEAD: begin
                // select low for a full sck period before the first rise
                if (ph == LEAD_M1) begin
                    next_state = ST_SHIFT;
                    next_ph    = '0;
                end
            end
            ST_SHIFT: begin
                if (ph_half) begin
                    next_sck = 1'b1;
                end else if (ph_full) begin
                    next_sck   = 1'b0;
                    next_ph    = '0;
                    next_fall  = 1'b1;
                    next_frame = frame_shl;
                    next_mosi  = frame[FRAME_BITS-2];
                    if (bit_last) begin
                        next_state = ST_TRAIL;
                        next_mosi  = 1'b0;
                    end else begin
                        next_bitn = bitn + 1'b1;
                    end
                end
            end
            ST_TRAIL: begin
                if (ph == TRAIL_M1) begin
                    next_state = ST_GAP;
                    next_ss_n  = 1'b1;
                    next_ph    = '0;
                    next_rsp   = !is_write;
                end
            end
            ST_GAP: begin
                // idle time after deselect before another access may start
                if (ph == GAP_M1) begin
                    next_state = ST_IDLE;
                    next_ph    = '0;
                end
            end
            default: begin
                next_state = ST_IDLE;
                next_ph    = '0;
                next_sck   = 1'b0;
                next_ss_n  = 1'b1;
                next_mosi  = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state    <= ST_IDLE;
            ph       <= '0;
            bitn     <= '0;
            frame    <= '0;
            is_write <= 1'b0;
        end else begin
            state    <= next_state;
            ph       <= next_ph;
            bitn     <= next_bitn;
            frame    <= next_frame;
            is_write <= next_is_write;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            sck_q  <= 1'b0;
            ss_n_q <= 1'b1;
            mosi_q <= 1'b0;
        end else begin
            sck_q  <= next_sck;
            ss_n_q <= next_ss_n;
            mosi_q <= next_mosi;
        end
    end

    // miso is from the sensor's sck domain; two flops before use
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            miso_s1 <= 1'b0;
            miso_s2 <= 1'b0;
        end else begin
            miso_s1 <= link.miso;
            miso_s2 <= miso_s1;
        end
    end

    // taken one cycle after our falling edge: the synchroniser then holds
    // the level from before that fall, i.e. the bit launched on the prior fall
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            samp_pend <= 1'b0;
            rx        <= '0;
        end else begin
            samp_pend <= next_fall;
            if (samp_pend)
                rx <= {rx[DATA_W-2:0], miso_s2};
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            rsp_valid <= 1'b0;
            rsp_rdata <= '0;
        end else begin
            rsp_valid <= next_rsp;
            if (next_rsp)
                rsp_rdata <= rx;
        end
    end
endmodule

// *** sim/scs_link_assertions.sv ***
// concurrent checks on the link between controller end and sensor end
`timescale 1ns/1ns
module scs_link_assertions (
    input  wire logic clk_sys,
    input  wire logic sys_rst,
    input  wire logic sck,
    input  wire logic ss_n,
    input  wire logic mosi,
    input  wire logic miso,
    input  wire logic miso_oe
);
    logic       sck_d;
    logic [5:0] rises;
    wire        sck_up = sck && !sck_d;

    // rise count per frame, cleared while deselected
    always_ff @(posedge clk_sys) begin
        sck_d <= sck;
        rises <= (ss_n || sys_rst) ? 6'h00 : rises + {5'h00, sck_up};
    end

    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    oe_idle_a: assert property (ss_n |-> !miso_oe) else $error("miso driven while deselected");
    oe_start_a: assert property ($rose(miso_oe) |-> rises == 6'h0a && !sck) else $error("read data starts late");
    oe_hold_a: assert property ($rose(miso_oe) |-> miso_oe [*8]) else $error("read data cut short");
    frame_len_a: assert property ($rose(ss_n) |-> rises == 6'h1a) else $error("frame not 26 bits");
    sel_lead_a: assert property ($fell(ss_n) |-> !sck [*2]) else $error("sck too soon after select");
    sel_trail_a: assert property ($rose(ss_n) |-> !$past(sck) && !$past(sck, 2)) else $error("deselect too soon");
    sel_gap_a: assert property ($rose(ss_n) |-> ss_n [*4]) else $error("gap between accesses short");
    sck_rate_a: assert property ($rose(sck) |=> !sck) else $error("sck high too long");
    sck_idle_a: assert property (ss_n |-> !sck) else $error("sck runs while deselected");
    mosi_edge_a: assert property (!ss_n && $changed(mosi) |-> $fell(sck) || $fell(ss_n))
        else $error("mosi changed off falling sck");

    cover property ($rose(miso_oe));
    cover property ($rose(ss_n) && !$past(miso_oe));
    cover property ($rose(ss_n) ##[4:20] $fell(ss_n));
endmodule

// *** sim/tb_sensor_config_serial_slave.sv ***
// self-checking bench: controller and sensor ends linked, plus a bench-driven link
`timescale 1ns/1ns
module tb_sensor_config_serial_slave;
    import scs_pkg::*;
    logic                  clk_sys = 1'b0;
    // raised just after time zero so the sck-side toggle sees a real reset edge
    logic                  sys_rst = 1'b0;
    logic                  req_valid = 1'b0;
    logic                  req_write = 1'b0;
    logic [ADDR_W-1:0]     req_addr = 9'h000;
    logic [DATA_W-1:0]     req_wdata = 16'h0000;
    logic                  req_ready;
    logic                  rsp_valid;
    logic [DATA_W-1:0]     rsp_rdata;
    logic                  wr_valid;
    logic [ADDR_W-1:0]     wr_addr;
    logic [DATA_W-1:0]     wr_data;
    logic                  wr_valid_b;
    logic [ADDR_W-1:0]     wr_addr_b;
    logic [DATA_W-1:0]     wr_data_b;
    logic [FRAME_BITS-1:0] cap;
    int                    n_checks = 0;
    int                    miscompares = 0;
    int                    wr_b_count = 0;

    scs_if i_link ();
    scs_if i_link_b ();

    scs_host #(.HALF(1)) i_scs_host (.clk_sys(clk_sys), .sys_rst(sys_rst), .req_valid(req_valid),
        .req_ready(req_ready), .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .link(i_link));
    scs_dev i_scs_dev (.clk_sys(clk_sys), .sys_rst(sys_rst), .link(i_link), .cfg_wr_valid(wr_valid),
        .cfg_wr_addr(wr_addr), .cfg_wr_data(wr_data));
    // second sensor end, driven by the bench so it can break the frame rules
    scs_dev i_scs_dev_b (.clk_sys(clk_sys), .sys_rst(sys_rst), .link(i_link_b), .cfg_wr_valid(wr_valid_b),
        .cfg_wr_addr(wr_addr_b), .cfg_wr_data(wr_data_b));
    scs_link_assertions u_chk (.clk_sys(clk_sys), .sys_rst(sys_rst), .sck(i_link.sck), .ss_n(i_link.ss_n),
        .mosi(i_link.mosi), .miso(i_link.miso), .miso_oe(i_link.miso_oe));

    always #25 clk_sys = ~clk_sys;
    always @(posedge i_link.sck) if (!i_link.ss_n) cap <= {cap[FRAME_BITS-2:0], i_link.mosi};
    always @(posedge clk_sys) if (wr_valid_b === 1'b1) wr_b_count <= wr_b_count + 1;

    task automatic chk(input string nm, input logic [FRAME_BITS-1:0] e, input logic [FRAME_BITS-1:0] g);
        n_checks++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // d is the write data, or the value a read must return
    task automatic host_acc(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        int n;
        @(negedge clk_sys);
        for (n = 0; n < 200 && req_ready !== 1'b1; n++) @(negedge clk_sys);
        @(posedge clk_sys);
        req_valid <= 1'b1;
        req_write <= wr;
        req_addr <= a;
        req_wdata <= d;
        @(posedge clk_sys);
        req_valid <= 1'b0;
        for (n = 0; n < 200 && (wr ? wr_valid : rsp_valid) !== 1'b1; n++) @(negedge clk_sys);
        chk("answer", 26'h0000001, {25'h0000000, n < 200});
        chk("frame", {a, wr, wr ? d : 16'h0000}, cap);
        if (wr) begin
            chk("wr_addr", {17'h00000, a}, {17'h00000, wr_addr});
            chk("wr_data", {10'h000, d}, {10'h000, wr_data});
        end else begin
            chk("rdata", {10'h000, d}, {10'h000, rsp_rdata});
        end
    endtask

    // bench as master on the second link; sck exists only inside the frame
    task automatic bb_frame(input logic [FRAME_BITS-1:0] f, input int nbits, output logic [DATA_W-1:0] rd);
        rd = 16'h0000;
        i_link_b.ss_n = 1'b0;
        #48;
        for (int i = 0; i < nbits; i++) begin
            i_link_b.mosi = f[FRAME_BITS-1-i];
            #24 i_link_b.sck = 1'b1;
            #24;
            if (i >= 10) rd = {rd[DATA_W-2:0], i_link_b.miso};
            if (i == 12 && f[DATA_W] == DIR_READ) chk("oe", 26'h0000001, {25'h0000000, i_link_b.miso_oe});
            i_link_b.sck = 1'b0;
        end
        #48 i_link_b.ss_n = 1'b1;
        i_link_b.mosi = ~i_link_b.mosi;
        #1 chk("oe_off", 26'h0000000, {25'h0000000, i_link_b.miso_oe});
        #95;
    endtask

    task automatic t_host_rw();
        logic [ADDR_W-1:0] a [3];
        logic [DATA_W-1:0] d [3];
        a = '{9'h000, 9'h1ff, 9'h0a5};
        d = '{16'hffff, 16'h8001, 16'h5a3c};
        for (int i = 0; i < 3; i++) host_acc(DIR_WRITE, a[i], d[i]);
        for (int i = 2; i >= 0; i--) host_acc(DIR_READ, a[i], d[i]);
    endtask

    task automatic t_link_abort();
        logic [DATA_W-1:0] rd;
        bb_frame({9'h133, DIR_WRITE, 16'hc3a5}, FRAME_BITS, rd);
        repeat (6) @(negedge clk_sys);
        chk("writes", 26'h0000001, wr_b_count[FRAME_BITS-1:0]);
        chk("waddr_b", {17'h00000, 9'h133}, {17'h00000, wr_addr_b});
        chk("wdata_b", {10'h000, 16'hc3a5}, {10'h000, wr_data_b});
        bb_frame({9'h133, DIR_WRITE, 16'h0ff0}, FRAME_BITS - 1, rd);
        repeat (8) @(negedge clk_sys);
        chk("writes", 26'h0000001, wr_b_count[FRAME_BITS-1:0]);
        bb_frame({9'h133, DIR_READ, 16'h0000}, FRAME_BITS, rd);
        chk("rdata_b", {10'h000, 16'hc3a5}, {10'h000, rd});
    endtask

    // first drive after time zero: the async clears must see an edge, not a start value
    initial begin
        #1;
        sys_rst <= 1'b1;
        i_link_b.ss_n = 1'b1;
        i_link_b.sck = 1'b0;
        i_link_b.mosi = 1'b0;
        repeat (4) @(posedge clk_sys);
        sys_rst <= 1'b0;
        t_host_rw();
        t_link_abort();
        stop_test();
    end

    // whole run needs about 25 us
    initial begin
        #100000;
        miscompares++;
        stop_test();
    end
endmodule
